// ===== tape_interlock_regs.svh
// register offsets, field positions, reset values and timing figures of the interlock sequencer
`ifndef TAPE_INTERLOCK_REGS_SVH
`define TAPE_INTERLOCK_REGS_SVH

`define CLK_HZ 20000000
`define POWER_DELAY_S 45
`define LOOP_DELAY_MS 20

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define CTRL_PULSE_LSB 0
`define CTRL_PULSE_W 8
`define CTRL_RESET 8'h10

`define ST_LATCH 0
`define ST_SERVO 1
`define ST_MOTION 2
`define ST_EOT 3
`define ST_FWD_ON 4
`define ST_REV_ON 5
`define ST_AUTO_READY 6
`define ST_DELAY 7
`define ST_WRITE 8

`define CMD_FWD_ON 0
`define CMD_FWD_OFF 1
`define CMD_REV_ON 2
`define CMD_REV_OFF 3

`endif

// ===== tape_interlock_pkg.sv
// types shared by the interlock sequencer files
package tape_interlock_pkg;

   typedef enum logic [2:0] {
      PWR_OFF = 3'h1,
      PWR_DELAY = 3'h2,
      PWR_LATCHED = 3'h4
   } power_state_type;

   typedef enum logic [1:0] {
      SRC_OFF = 2'h0,
      SRC_AUTO = 2'h1,
      SRC_MANUAL = 2'h2
   } src_type;

   typedef enum logic [2:0] {
      MOT_STOP = 3'h0,
      MOT_FWD = 3'h1,
      MOT_FAST_FWD = 3'h2,
      MOT_REV = 3'h3,
      MOT_FAST_REV = 3'h4
   } motion_type;

endpackage

// ===== sync_bank.sv
// two-stage synchroniser bank for switch and sensor inputs
`timescale 1ns/1ns
module sync_bank #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] rawIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage_r;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               stage_r[i] <= 1'b0;
               syncOut[i] <= 1'b0;
            end else begin
               stage_r[i] <= rawIn[i];
               syncOut[i] <= stage_r[i];
            end
         end
      end
   endgenerate

endmodule

// ===== tape_interlock_sequencer.sv
// power, command source and motion interlock sequencer of the tape transport panel
// Functional notes
// [RQ1] main power switch on: wait 45 s, then assert power delay output to set latch
// [RQ2] latch holds itself; delay timer loses drive and returns idle
// [RQ3] latch drives the safety chain; its return is the interlock complete level
// [RQ4] power indicator lit whenever the latch is set
// [RQ5] automatic mode with interlock complete sets servo power: drive on, brakes off
// [RQ6] automatic mode with loops normal sets motion flag, passing automatic commands
// [RQ7] automatic mode with interlock complete drives the automatic ready output
// [RQ8] automatic loop fault clears the motion flag after a 20 ms delay
// [RQ9] motion flag clearing cuts automatic commands and pulses OFF to both actuators
// [RQ10] automatic motion flag sets again once the loop fault clears
// [RQ11] losing the interlock in automatic clears motion and servo flags until restored
// [RQ12] manual mode also sets servo power, only while the interlock is complete
// [RQ13] manual motion flag sets with loops normal, no tape end, selector at STOP
// [RQ14] operator entering manual away from STOP must visit STOP first; a motion flag set in automatic is kept when switched straight to manual
// [RQ15] manual commands only while motion flag set; no ON before interlock complete
// [RQ16] manual tape end sensing sets end flag, breaking the motion flag hold
// [RQ17] manual write switch with interlock complete asserts manual write enable
// [RQ18] selector's five conditions act only in manual with power, servo, motion set
// [RQ19] forward and reverse ON commands never presented together
// [RQ20] selecting forward issues an ON command to the forward actuator
// [RQ21] return to STOP issues OFF to the actuator that was on
// [RQ22] actuators stay on until OFF; dropping the enable alone stops nothing
// [RQ23] commands are fixed width pulses, delays in clocks, inputs synchronised
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ns
`include "tape_interlock_regs.svh"
module tape_interlock_sequencer #(
   parameter int unsigned POWER_DELAY_CYC = `POWER_DELAY_S * `CLK_HZ,
   parameter int unsigned LOOP_DELAY_CYC = `LOOP_DELAY_MS * (`CLK_HZ / 1000)
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatWr,
   output logic [31:0] wbDatRd,
   output logic wbAck,
   input wire logic mainPowerSwitch,
   input wire tape_interlock_pkg::src_type commandSourceSelector,
   input wire tape_interlock_pkg::motion_type motionSelector,
   input wire logic chainReturn,
   input wire logic loopNormal,
   input wire logic tapeEndSense,
   input wire logic manualWriteSwitch,
   input wire logic autoFwdCmd,
   input wire logic autoRevCmd,
   output logic powerOnDelay,
   output logic safetyChainDrive,
   output logic powerIndicator,
   output logic servoDrive,
   output logic brakeRelease,
   output logic autoReady,
   output logic manualWriteEnable,
   output logic fastWind,
   output logic fwdOnPulse,
   output logic fwdOffPulse,
   output logic revOnPulse,
   output logic revOffPulse
);
   import tape_interlock_pkg::*;

   localparam int PW = $clog2(POWER_DELAY_CYC + 1);
   localparam int LW = $clog2(LOOP_DELAY_CYC + 1);

   function automatic logic isFwd(input motion_type m);
      isFwd = (m == MOT_FWD) || (m == MOT_FAST_FWD);
   endfunction

   function automatic logic isRev(input motion_type m);
      isRev = (m == MOT_REV) || (m == MOT_FAST_REV);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [11:0] syncVec;
   sync_bank #(.WIDTH(12)) u_sync ( // RQ23
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .rawIn({autoRevCmd, autoFwdCmd, manualWriteSwitch, tapeEndSense, loopNormal,
              chainReturn, mainPowerSwitch, motionSelector, commandSourceSelector}),
      .syncOut(syncVec)
   );

   src_type srcSel;
   motion_type motSel;
   logic mainSw, chainOk, loopOk, tapeEnd, writeSw, autoFwd, autoRev;
   assign srcSel = src_type'(syncVec[1:0]);
   assign motSel = motion_type'(syncVec[4:2]);
   assign mainSw = syncVec[5];
   assign chainOk = syncVec[6];
   assign loopOk = syncVec[7];
   assign tapeEnd = syncVec[8];
   assign writeSw = syncVec[9];
   assign autoFwd = syncVec[10];
   assign autoRev = syncVec[11];

   ////////////////////////////////////////////////////////////////////////////
   // power delay and latch
   power_state_type pwrState_r;
   logic [PW-1:0] powerCnt_r;
   logic powerDelay_r, powerLatch_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pwrState_r <= PWR_OFF;
         powerCnt_r <= '0;
         powerDelay_r <= 1'b0;
      end else begin
         powerDelay_r <= 1'b0;
         unique case (pwrState_r)
            PWR_OFF: begin
               powerCnt_r <= '0;
               if (mainSw) begin
                  pwrState_r <= PWR_DELAY;
               end
            end
            PWR_DELAY: begin
               if (!mainSw) begin
                  pwrState_r <= PWR_OFF;
                  powerCnt_r <= '0;
               end else if (powerCnt_r == PW'(POWER_DELAY_CYC - 1)) begin
                  powerDelay_r <= 1'b1; // RQ1
                  pwrState_r <= PWR_LATCHED;
               end else begin
                  powerCnt_r <= powerCnt_r + PW'(1);
               end
            end
            PWR_LATCHED: begin
               powerCnt_r <= '0; // RQ2
               if (!mainSw) begin
                  pwrState_r <= PWR_OFF;
               end
            end
            default: begin
               pwrState_r <= PWR_OFF;
               powerCnt_r <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         powerLatch_r <= 1'b0;
      end else begin
         powerLatch_r <= mainSw && (powerDelay_r || powerLatch_r); // RQ2
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode flags
   logic interlockOk, srcAuto, srcManual, loopExpired;
   logic servoPower_r, motionFlag_r, motionPrev_r, endOfTape_r;
   logic autoReady_r, manualWrite_r, fastWind_r, indicator_r, chainDrive_r;
   logic [LW-1:0] loopCnt_r;

   assign interlockOk = powerLatch_r && chainOk; // RQ3
   assign srcAuto = (srcSel == SRC_AUTO);
   assign srcManual = (srcSel == SRC_MANUAL);
   assign loopExpired = (loopCnt_r == LW'(LOOP_DELAY_CYC - 1));

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chainDrive_r <= 1'b0;
         indicator_r <= 1'b0;
         servoPower_r <= 1'b0;
         autoReady_r <= 1'b0;
         manualWrite_r <= 1'b0;
         endOfTape_r <= 1'b0;
      end else begin
         chainDrive_r <= powerLatch_r; // RQ3
         indicator_r <= powerLatch_r; // RQ4
         servoPower_r <= interlockOk && (srcAuto || srcManual); // RQ5 RQ11 RQ12
         autoReady_r <= srcAuto && interlockOk; // RQ7
         manualWrite_r <= srcManual && interlockOk && writeSw; // RQ17
         endOfTape_r <= srcManual && interlockOk && tapeEnd; // RQ16
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         loopCnt_r <= '0;
      end else if (loopOk || !motionFlag_r || loopExpired) begin
         loopCnt_r <= '0;
      end else begin
         loopCnt_r <= loopCnt_r + LW'(1); // RQ8
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         motionFlag_r <= 1'b0;
         motionPrev_r <= 1'b0;
      end else begin
         motionPrev_r <= motionFlag_r;
         if (!interlockOk || !(srcAuto || srcManual)) begin
            motionFlag_r <= 1'b0; // RQ11
         end else if (loopExpired) begin
            motionFlag_r <= 1'b0; // RQ8
         end else if (srcAuto && loopOk) begin
            motionFlag_r <= 1'b1; // RQ6 RQ10
         end else if (srcManual && endOfTape_r) begin
            motionFlag_r <= 1'b0; // RQ16
         end else if (srcManual && loopOk && !tapeEnd && motSel == MOT_STOP) begin
            motionFlag_r <= 1'b1; // RQ13 RQ14
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // actuator command pulses
   logic [`CTRL_PULSE_W-1:0] pulseWidth_r, pulseCnt_r;
   logic [3:0] cmdReq, pend_r, issue, actCmd_r;
   logic fwdOn_r, revOn_r, autoFwdPrev_r, autoRevPrev_r, manualArmed;
   motion_type selPrev_r;

   assign manualArmed = srcManual && motionFlag_r && servoPower_r && powerLatch_r; // RQ18

   always_comb begin
      cmdReq = 4'h0;
      if (motionPrev_r && !motionFlag_r) begin
         cmdReq[`CMD_FWD_OFF] = 1'b1; // RQ9
         cmdReq[`CMD_REV_OFF] = 1'b1;
      end else if (srcAuto && motionFlag_r) begin
         cmdReq[`CMD_FWD_ON] = autoFwd && !autoFwdPrev_r; // RQ6
         cmdReq[`CMD_FWD_OFF] = !autoFwd && autoFwdPrev_r;
         cmdReq[`CMD_REV_ON] = autoRev && !autoRevPrev_r;
         cmdReq[`CMD_REV_OFF] = !autoRev && autoRevPrev_r;
      end else if (manualArmed && motSel != selPrev_r) begin // RQ15
         cmdReq[`CMD_FWD_ON] = isFwd(motSel); // RQ20
         cmdReq[`CMD_REV_ON] = isRev(motSel);
         cmdReq[`CMD_FWD_OFF] = (motSel == MOT_STOP) && fwdOn_r; // RQ21
         cmdReq[`CMD_REV_OFF] = (motSel == MOT_STOP) && revOn_r;
      end
   end

   always_comb begin
      issue = pend_r | cmdReq;
      if (issue[`CMD_FWD_OFF]) begin
         issue[`CMD_FWD_ON] = 1'b0;
      end
      if (issue[`CMD_REV_OFF]) begin
         issue[`CMD_REV_ON] = 1'b0;
      end
      if ((issue[`CMD_FWD_ON] && (issue[`CMD_REV_ON] || revOn_r))
          || (issue[`CMD_REV_ON] && fwdOn_r)) begin
         issue[`CMD_FWD_ON] = 1'b0; // RQ19
         issue[`CMD_REV_ON] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         selPrev_r <= MOT_STOP;
         autoFwdPrev_r <= 1'b0;
         autoRevPrev_r <= 1'b0;
      end else begin
         selPrev_r <= motSel;
         autoFwdPrev_r <= autoFwd;
         autoRevPrev_r <= autoRev;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= 4'h0;
         actCmd_r <= 4'h0;
         pulseCnt_r <= '0;
      end else if (pulseCnt_r != '0) begin
         pulseCnt_r <= pulseCnt_r - `CTRL_PULSE_W'(1); // RQ23
         if (pulseCnt_r == `CTRL_PULSE_W'(1)) begin
            actCmd_r <= 4'h0;
         end
         pend_r <= pend_r | cmdReq;
      end else begin
         pend_r <= 4'h0;
         actCmd_r <= issue;
         if (issue != 4'h0) begin
            pulseCnt_r <= (pulseWidth_r == '0) ? `CTRL_PULSE_W'(1) : pulseWidth_r;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fwdOn_r <= 1'b0;
         revOn_r <= 1'b0;
      end else if (pulseCnt_r == '0) begin
         fwdOn_r <= (fwdOn_r || issue[`CMD_FWD_ON]) && !issue[`CMD_FWD_OFF]; // RQ22
         revOn_r <= (revOn_r || issue[`CMD_REV_ON]) && !issue[`CMD_REV_OFF];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fastWind_r <= 1'b0;
      end else begin
         fastWind_r <= manualArmed && (motSel == MOT_FAST_FWD || motSel == MOT_FAST_REV);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave
   logic wbAck_r;
   logic [31:0] wbDat_r;
   logic [8:0] statusWord;

   assign statusWord = {manualWrite_r, powerDelay_r, autoReady_r, revOn_r, fwdOn_r,
                        endOfTape_r, motionFlag_r, servoPower_r, powerLatch_r};

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wbAck_r <= 1'b0;
         wbDat_r <= 32'h0;
      end else begin
         wbAck_r <= wbCyc && wbStb && !wbAck_r;
         if (wbCyc && wbStb && !wbAck_r) begin
            unique case (wbAdr)
               `REG_CTRL: wbDat_r <= {24'h0, pulseWidth_r};
               `REG_STATUS: wbDat_r <= {23'h0, statusWord};
               default: wbDat_r <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pulseWidth_r <= `CTRL_RESET;
      end else if (wbCyc && wbStb && wbWe && wbAck_r && wbSel[0] && wbAdr == `REG_CTRL) begin
         pulseWidth_r <= wbDatWr[`CTRL_PULSE_LSB +: `CTRL_PULSE_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign wbAck = wbAck_r;
   assign wbDatRd = wbDat_r;
   assign powerOnDelay = powerDelay_r;
   assign safetyChainDrive = chainDrive_r;
   assign powerIndicator = indicator_r;
   assign servoDrive = servoPower_r;
   assign brakeRelease = servoPower_r;
   assign autoReady = autoReady_r;
   assign manualWriteEnable = manualWrite_r;
   assign fastWind = fastWind_r;
   assign fwdOnPulse = actCmd_r[`CMD_FWD_ON];
   assign fwdOffPulse = actCmd_r[`CMD_FWD_OFF];
   assign revOnPulse = actCmd_r[`CMD_REV_ON];
   assign revOffPulse = actCmd_r[`CMD_REV_OFF];

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   delay_done_a: assert property ($rose(powerDelay_r) |-> $past(powerCnt_r) == PW'(POWER_DELAY_CYC - 1)) // RQ1
      else $error("power delay output before full delay");
   latch_hold_a: assert property ((pwrState_r == PWR_LATCHED && mainSw) |=> (pwrState_r == PWR_LATCHED && powerCnt_r == '0)) // RQ2
      else $error("latch lost or timer running");
   indicator_chain_a: assert property (powerIndicator |-> safetyChainDrive) // RQ4
      else $error("indicator without chain drive");
   servo_cause_a: assert property (servoPower_r |-> $past(interlockOk && (srcAuto || srcManual))) // RQ5
      else $error("servo power without interlock");
   auto_ready_a: assert property (autoReady_r |-> $past(srcAuto && interlockOk)) // RQ7
      else $error("auto ready without cause");
   loop_grace_a: assert property ((srcAuto && interlockOk && motionFlag_r && !loopExpired) |=> motionFlag_r) // RQ8
      else $error("motion flag dropped before loop delay");
   off_both_a: assert property ((motionPrev_r && !motionFlag_r) |-> ##[0:600] (fwdOffPulse && revOffPulse)) // RQ9
      else $error("no off pulses after interlock loss");
   manual_stop_a: assert property (($rose(motionFlag_r) && $past(srcManual)) |-> $past(motSel) == MOT_STOP) // RQ13
      else $error("manual motion flag set away from stop");
   tape_end_a: assert property (endOfTape_r |=> !motionFlag_r) // RQ16
      else $error("tape end did not break motion hold");
   mutual_on_a: assert property (!(fwdOnPulse && revOnPulse) && !(fwdOn_r && revOn_r)) // RQ19
      else $error("both actuators commanded on");
   write_en_a: assert property (manualWrite_r |-> $past(srcManual && interlockOk && writeSw)) // RQ17
      else $error("manual write without cause");

   latch_set_c: cover property ($rose(powerLatch_r));
   fwd_on_c: cover property ($rose(fwdOnPulse) && srcManual);
   loop_off_c: cover property (srcAuto && $fell(motionFlag_r) ##[1:20] fwdOffPulse);

endmodule

// ===== auto_programmer.sv
// automatic programming controller issuing forward and reverse level commands
`timescale 1ns/1ns
module auto_programmer (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic goFwd,
   input wire logic goRev,
   input wire logic [3:0] lagCyc,
   output logic autoFwdCmd,
   output logic autoRevCmd
);
   logic [3:0] lag_r;

   // samples the requested direction once every lagCyc+1 cycles, never both at once
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         autoFwdCmd <= 1'b0;
         autoRevCmd <= 1'b0;
         lag_r <= 4'h0;
      end else if (lag_r != 4'h0) begin
         lag_r <= lag_r - 4'h1;
      end else begin
         autoFwdCmd <= goFwd && !goRev;
         autoRevCmd <= goRev && !goFwd;
         lag_r <= lagCyc;
      end
   end
endmodule

// ===== tape_interlock_sequencer_test.sv
// self-checking bench for the tape transport interlock sequencer
`timescale 1ns/1ns
`include "tape_interlock_regs.svh"
module tape_interlock_sequencer_test;
   import tape_interlock_pkg::*;
   localparam int PW = 4;
   logic clk_sys, rst_n, wbCyc, wbStb, wbWe, wbAck, goFwd, goRev;
   logic [7:0] wbAdr;
   logic [3:0] wbSel, lagCyc;
   logic [31:0] wbDatWr, wbDatRd, rd;
   logic mainPowerSwitch, chainReturn, loopNormal, tapeEndSense, manualWriteSwitch;
   logic autoFwdCmd, autoRevCmd, powerOnDelay, safetyChainDrive, powerIndicator;
   logic servoDrive, brakeRelease, autoReady, manualWriteEnable, fastWind;
   logic fwdOnPulse, fwdOffPulse, revOnPulse, revOffPulse;
   src_type commandSourceSelector;
   motion_type motionSelector;
   int n_mismatch, checks_done, overlap, t;
   int pc[4];
   int s[4];

   tape_interlock_sequencer #(.POWER_DELAY_CYC(50), .LOOP_DELAY_CYC(20)) i_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbAdr(wbAdr), .wbSel(wbSel), .wbDatWr(wbDatWr), .wbDatRd(wbDatRd), .wbAck(wbAck),
      .mainPowerSwitch(mainPowerSwitch), .commandSourceSelector(commandSourceSelector),
      .motionSelector(motionSelector), .chainReturn(chainReturn), .loopNormal(loopNormal),
      .tapeEndSense(tapeEndSense), .manualWriteSwitch(manualWriteSwitch),
      .autoFwdCmd(autoFwdCmd), .autoRevCmd(autoRevCmd), .powerOnDelay(powerOnDelay),
      .safetyChainDrive(safetyChainDrive), .powerIndicator(powerIndicator),
      .servoDrive(servoDrive), .brakeRelease(brakeRelease), .autoReady(autoReady),
      .manualWriteEnable(manualWriteEnable), .fastWind(fastWind), .fwdOnPulse(fwdOnPulse),
      .fwdOffPulse(fwdOffPulse), .revOnPulse(revOnPulse), .revOffPulse(revOffPulse));

   auto_programmer i_prog (.clk_sys(clk_sys), .rst_n(rst_n), .goFwd(goFwd), .goRev(goRev),
      .lagCyc(lagCyc), .autoFwdCmd(autoFwdCmd), .autoRevCmd(autoRevCmd));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pulse cycle counters and overlap watch
   always @(posedge clk_sys) begin
      if (fwdOnPulse === 1'b1) pc[0]++;
      if (fwdOffPulse === 1'b1) pc[1]++;
      if (revOnPulse === 1'b1) pc[2]++;
      if (revOffPulse === 1'b1) pc[3]++;
      if (fwdOnPulse !== 1'b0 && revOnPulse !== 1'b0) overlap++;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check1(input logic got, input logic exp);
      check({31'h0, got}, {31'h0, exp});
   endtask

   task automatic delta(input int i, input int e);
      check(32'(pc[i] - s[i]), 32'(e));
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic conclude();
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one classic cycle; held until ack is sampled high, released at that same edge
   task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] sel,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbSel <= sel;
      wbDatWr <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'b1 && n < 40);
      rd = wbDatRd;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (n >= 40) check(32'h0, 32'h1);
   endtask

   task automatic pollStatus(input int idx, input logic val);
      int n;
      n = 0;
      do begin
         xfer(1'b0, `REG_STATUS, 4'hF, 32'h0);
         n++;
      end while (rd[idx] !== val && n < 60);
      check1(rd[idx], val);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      conclude();
   end

   initial begin
      rst_n = 1'b0;
      {wbCyc, wbStb, wbWe, goFwd, goRev} = 5'h00;
      {wbAdr, wbSel, wbDatWr, lagCyc} = 48'h0;
      {mainPowerSwitch, chainReturn, tapeEndSense, manualWriteSwitch} = 4'h0;
      loopNormal = 1'b1;
      commandSourceSelector = SRC_OFF;
      motionSelector = MOT_STOP;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      xfer(1'b0, `REG_CTRL, 4'hF, 32'h0);
      check(rd, 32'h10);
      xfer(1'b1, `REG_CTRL, 4'h0, 32'(PW));
      xfer(1'b0, `REG_CTRL, 4'hF, 32'h0);
      check(rd, 32'h10);
      xfer(1'b1, `REG_CTRL, 4'hF, 32'(PW));
      xfer(1'b0, `REG_CTRL, 4'hF, 32'h0);
      check(rd, 32'(PW));
      xfer(1'b0, 8'h08, 4'hF, 32'h0);
      check(rd, 32'h0);
      mainPowerSwitch <= 1'b1;
      t = 0;
      do begin
         @(negedge clk_sys);
         t++;
      end while (powerOnDelay !== 1'b1 && t < 500);
      check1(t >= 50 && t <= 56, 1'b1);
      pollStatus(`ST_LATCH, 1'b1);
      settle(3);
      check1(powerIndicator, 1'b1);
      check1(safetyChainDrive, 1'b1);
      check1(rd[`ST_DELAY], 1'b0);
      commandSourceSelector <= SRC_AUTO;
      settle(8);
      check1(servoDrive, 1'b0);
      chainReturn <= 1'b1;
      pollStatus(`ST_SERVO, 1'b1);
      settle(2);
      check1(brakeRelease, 1'b1);
      check1(autoReady, 1'b1);
      pollStatus(`ST_MOTION, 1'b1);
      s = pc;
      goFwd <= 1'b1;
      pollStatus(`ST_FWD_ON, 1'b1);
      settle(10);
      delta(0, PW);
      loopNormal <= 1'b0;
      settle(12);
      pollStatus(`ST_MOTION, 1'b1);
      s = pc;
      pollStatus(`ST_MOTION, 1'b0);
      settle(10);
      delta(1, PW);
      delta(3, PW);
      goFwd <= 1'b0;
      lagCyc <= 4'h5;
      loopNormal <= 1'b1;
      pollStatus(`ST_MOTION, 1'b1);
      s = pc;
      goRev <= 1'b1;
      pollStatus(`ST_REV_ON, 1'b1);
      settle(10);
      delta(2, PW);
      chainReturn <= 1'b0;
      pollStatus(`ST_SERVO, 1'b0);
      pollStatus(`ST_MOTION, 1'b0);
      settle(10);
      pollStatus(`ST_SERVO, 1'b0);
      goRev <= 1'b0;
      commandSourceSelector <= SRC_MANUAL;
      motionSelector <= MOT_FWD;
      settle(8);
      check1(servoDrive, 1'b0);
      s = pc;
      chainReturn <= 1'b1;
      pollStatus(`ST_SERVO, 1'b1);
      settle(10);
      pollStatus(`ST_MOTION, 1'b0);
      delta(0, 0);
      motionSelector <= MOT_STOP;
      pollStatus(`ST_MOTION, 1'b1);
      manualWriteSwitch <= 1'b1;
      settle(6);
      check1(manualWriteEnable, 1'b1);
      for (int i = 1; i <= 4; i++) begin
         s = pc;
         motionSelector <= motion_type'(i);
         pollStatus(i >= 3 ? `ST_REV_ON : `ST_FWD_ON, 1'b1);
         settle(8);
         check1(fastWind, i == 2 || i == 4);
         delta(i >= 3 ? 2 : 0, PW);
         motionSelector <= MOT_STOP;
         pollStatus(i >= 3 ? `ST_REV_ON : `ST_FWD_ON, 1'b0);
         settle(8);
         delta(i >= 3 ? 3 : 1, PW);
      end
      check(32'(overlap), 32'h0);
      motionSelector <= MOT_FWD;
      pollStatus(`ST_FWD_ON, 1'b1);
      s = pc;
      settle(20);
      pollStatus(`ST_FWD_ON, 1'b1);
      delta(1, 0);
      tapeEndSense <= 1'b1;
      pollStatus(`ST_EOT, 1'b1);
      pollStatus(`ST_MOTION, 1'b0);
      settle(10);
      delta(1, PW);
      conclude();
   end
endmodule
